// *** verilog/boot_strap_sampler.sv ***
// Boot strap sampler: captures, decodes and publishes the boot configuration straps.
`timescale 1ns/100ps
`default_nettype none
module boot_strap_sampler (
    // Clock and core reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Board pins, asynchronous to the core clock.
    input wire logic fundamental_reset_n,
    input wire logic common_clock_down_strap,
    input wire logic common_clock_up_strap,
    input wire logic master_bus_slow_strap,
    input wire logic merge_ports_0_1_strap,
    input wire logic merge_ports_2_3_strap,
    input wire logic merge_ports_4_5_strap,
    input wire logic merge_ports_6_7_strap,
    input wire logic ref_clock_rate_strap,
    input wire logic reset_hold_strap,
    input wire logic [3:0] operating_mode_strap,
    // Configuration loader register writes and completion.
    input wire boot_strap_pkg::reg_write_t loader_write,
    input wire logic loader_done,
    output logic loader_request,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Reset sequencing outputs.
    output logic fund_reset_active,
    output logic core_hold,
    output logic bus_enable,
    // Decoded configuration.
    output logic common_clock_down,
    output logic common_clock_up,
    output logic bus_slow,
    output logic bus_tick,
    output logic [3:0] port_merged,
    output logic [3:0] odd_port_enabled,
    output logic ref_clock_125,
    output logic [7:0] ref_clock_mhz,
    output boot_strap_pkg::mode_dec_t mode
);
    localparam int SYNC_W = boot_strap_pkg::STRAP_W + 1;

    boot_strap_pkg::strap_vec_t pin_vec;
    boot_strap_pkg::strap_vec_t strap_sync_vec;
    boot_strap_pkg::strap_vec_t captured_reg;
    boot_strap_pkg::seq_state_t state_reg;
    boot_strap_pkg::seq_state_t state_next;
    boot_strap_pkg::mode_dec_t dec_w;
    logic [SYNC_W-1:0] sync_w;
    logic pin_high;
    logic capture;
    logic warm_go;
    logic hold_seen_reg;
    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    logic ahb_wr_reg;
    logic [7:0] ahb_addr_reg;
    logic wr_any;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_ctrl;
    logic ovr_ok;
    logic addr_phase;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [7:0] div_cnt_reg;
    logic [7:0] div_limit;
    logic [3:0] odd_w;

    // Gather the pins so that strap and release edge travel the same pipeline.
    assign pin_vec.common_down = common_clock_down_strap;
    assign pin_vec.common_up = common_clock_up_strap;
    assign pin_vec.bus_slow = master_bus_slow_strap;
    assign pin_vec.merge = {merge_ports_6_7_strap, merge_ports_4_5_strap,
        merge_ports_2_3_strap, merge_ports_0_1_strap};
    assign pin_vec.ref_rate = ref_clock_rate_strap;
    assign pin_vec.hold = reset_hold_strap;
    assign pin_vec.mode = operating_mode_strap;

    strap_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({fundamental_reset_n, pin_vec}),
        .sync_out(sync_w)
    );

    assign pin_high = sync_w[SYNC_W-1];
    assign strap_sync_vec = sync_w[SYNC_W-2:0];

    // Sample only on the release, while the sequencer waits on the pin.
    // capture on release
    assign capture = (state_reg == boot_strap_pkg::ST_PIN_RESET) && pin_high;

    // AHB-Lite address phase and merged write path from bus or loader.
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_any = loader_write.valid || ahb_wr_reg;
    assign wr_addr = loader_write.valid ? loader_write.addr : ahb_addr_reg;
    assign wr_data = loader_write.valid ? loader_write.data : hwdata;
    assign wr_ctrl = wr_any && (wr_addr[7:2] == boot_strap_pkg::CTRL_ADDR[7:2]);
    assign ovr_ok = (state_reg != boot_strap_pkg::ST_RUN);
    assign warm_go = wr_ctrl && wr_data[boot_strap_pkg::CTRL_WARM_BIT] &&
        (state_reg == boot_strap_pkg::ST_RUN);

    // Control fields: [0] hold, [1] common down, [2] common up.
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (capture)
        begin
            ctrl_next = {strap_sync_vec.common_up, strap_sync_vec.common_down, strap_sync_vec.hold};
        end
        else if (warm_go)
        begin
            ctrl_next = {captured_reg.common_up, captured_reg.common_down, captured_reg.hold};
        end
        else if (wr_ctrl)
        begin
            ctrl_next[0] = wr_data[boot_strap_pkg::CTRL_HOLD_BIT];
            if (ovr_ok)
            begin
                ctrl_next[1] = wr_data[boot_strap_pkg::CTRL_CDOWN_BIT];
                ctrl_next[2] = wr_data[boot_strap_pkg::CTRL_CUP_BIT];
            end
        end
    end

    // Reset sequence: pin reset, optional EEPROM load, optional hold, run.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            boot_strap_pkg::ST_PIN_RESET:
            begin
                if (capture)
                begin
                    state_next = boot_strap_pkg::ST_LOAD;
                end
            end
            boot_strap_pkg::ST_LOAD:
            begin
                // The registered decode lags the capture by a cycle, so use the live one.
                if (!dec_w.eeprom_init || loader_done)
                begin
                    state_next = ctrl_reg[0] ? boot_strap_pkg::ST_HOLD : boot_strap_pkg::ST_RUN;
                end
            end
            boot_strap_pkg::ST_HOLD:
            begin
                if (!ctrl_reg[0])
                begin
                    state_next = boot_strap_pkg::ST_RUN;
                end
            end
            boot_strap_pkg::ST_RUN:
            begin
                if (warm_go)
                begin
                    state_next = boot_strap_pkg::ST_LOAD;
                end
            end
        endcase
    end

    // The pin low forces the sequence back, but the captured vector survives
    // so that a later warm reset can reuse it.
    // pin resets logic
    always_ff @(posedge ref_clk)
    begin
        if (reset || !pin_high)
        begin
            state_reg <= boot_strap_pkg::ST_PIN_RESET;
            ctrl_reg <= boot_strap_pkg::CTRL_RESET;
        end
        else
        begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // Captured vector and hold indication change only on a release.
    // straps ignored otherwise
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            captured_reg <= boot_strap_pkg::STRAP_RESET;
            hold_seen_reg <= 1'b0;
        end
        else if (capture)
        begin
            captured_reg <= strap_sync_vec;
            hold_seen_reg <= strap_sync_vec.hold;
        end
    end

    // Register words as seen by software.
    assign ctrl_word = {28'h0000000, ctrl_reg[2], ctrl_reg[1], 1'b0, ctrl_reg[0]};
    assign status_word = {14'h0000, state_reg == boot_strap_pkg::ST_RUN, hold_seen_reg,
        3'h0, captured_reg};
    assign rd_word = (haddr[7:2] == boot_strap_pkg::CTRL_ADDR[7:2]) ? ctrl_word :
        (haddr[7:2] == boot_strap_pkg::STATUS_ADDR[7:2]) ? status_word : 32'h00000000;

    // Zero-wait slave: read data is latched in the address phase.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ahb_wr_reg <= 1'b0;
            ahb_addr_reg <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            ahb_wr_reg <= addr_phase && hwrite;
            ahb_addr_reg <= haddr[7:0];
            if (addr_phase && !hwrite)
            begin
                hrdata <= (|haddr[31:8]) ? 32'h00000000 : rd_word;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    mode_decode #(
        .PAIRS(4)
    ) u_decode (
        .mode(captured_reg.mode),
        .merge(captured_reg.merge),
        .dec(dec_w),
        .odd_port_enabled(odd_w)
    );

    // Decoded outputs are registered so consumers see clean levels.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mode <= '0;
            port_merged <= 4'h0;
            odd_port_enabled <= 4'hF;
            ref_clock_125 <= 1'b0;
            ref_clock_mhz <= boot_strap_pkg::REF_MHZ_LOW;
            bus_slow <= 1'b0;
        end
        else
        begin
            mode <= dec_w;
            port_merged <= captured_reg.merge;
            odd_port_enabled <= odd_w;
            ref_clock_125 <= captured_reg.ref_rate;
            ref_clock_mhz <= captured_reg.ref_rate ? boot_strap_pkg::REF_MHZ_HIGH : boot_strap_pkg::REF_MHZ_LOW;
            bus_slow <= captured_reg.bus_slow;
        end
    end

    assign common_clock_down = ctrl_reg[1];
    assign common_clock_up = ctrl_reg[2];

    // Sequencer levels; the buses stay alive through the hold state.
    assign fund_reset_active = (state_reg == boot_strap_pkg::ST_PIN_RESET);
    assign core_hold = (state_reg != boot_strap_pkg::ST_RUN);
    assign bus_enable = pin_high;
    assign loader_request = (state_reg == boot_strap_pkg::ST_LOAD) && dec_w.eeprom_init;

    // Master bus bit-rate enable; the fast divider rounds down to 62 cycles, so it exceeds 400 kHz
    // by no more than the 25 MHz granularity allows.
    // master bus rate
    assign div_limit = bus_slow ? 8'(boot_strap_pkg::BUS_SLOW_CYC - 1) : 8'(boot_strap_pkg::BUS_FAST_CYC - 1);

    always_ff @(posedge ref_clk)
    begin
        if (reset || !bus_enable)
        begin
            div_cnt_reg <= 8'h00;
            bus_tick <= 1'b0;
        end
        else
        begin
            bus_tick <= (div_cnt_reg >= div_limit);
            div_cnt_reg <= (div_cnt_reg >= div_limit) ? 8'h00 : div_cnt_reg + 8'h01;
        end
    end

    // Checks on the sequencing and the published values.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence seq_release;
        state_reg == boot_strap_pkg::ST_PIN_RESET && pin_high;
    endsequence

    sequence seq_warm;
        warm_go && pin_high;
    endsequence

    AST_CAPTURE_ON_RELEASE: assert property (seq_release |=> captured_reg == $past(strap_sync_vec))
        else $error("Strap vector not captured at release");

    AST_STRAPS_IGNORED: assert property (state_reg != boot_strap_pkg::ST_PIN_RESET |=> $stable(captured_reg))
        else $error("Captured straps changed outside reset");

    AST_NO_OVERRIDE_RUN: assert property (state_reg == boot_strap_pkg::ST_RUN && !warm_go && pin_high
        |=> $stable(common_clock_down) && $stable(common_clock_up))
        else $error("Common clock value changed while running");

    AST_STATUS_SHOWS: assert property (seq_release |=> status_word[12:0] == $past(strap_sync_vec))
        else $error("Status does not show captured straps");

    AST_BUS_GAP: assert property (bus_tick && !bus_slow && $stable(bus_slow) |=> !bus_tick [*8])
        else $error("Master bus tick spacing too short");

    AST_PIN_RESETS: assert property (!pin_high |=> fund_reset_active && core_hold && ctrl_reg == 3'h0)
        else $error("Pin reset did not reset the sequence");

    AST_MERGE: assert property ($stable(captured_reg) [*2] |-> odd_port_enabled == ~port_merged)
        else $error("Odd port enable disagrees with merge");

    AST_REF_RATE: assert property (seq_release ##2 $stable(captured_reg)
        |-> ref_clock_mhz == (captured_reg.ref_rate ? 8'h7D : 8'h64))
        else $error("Reference clock rate decode wrong");

    AST_HOLD_BUSES: assert property (state_reg == boot_strap_pkg::ST_HOLD && pin_high |-> core_hold && bus_enable)
        else $error("Hold state lost bus enable");

    AST_HOLD_EXIT: assert property (state_reg == boot_strap_pkg::ST_HOLD && !ctrl_reg[0] && pin_high
        |=> state_reg == boot_strap_pkg::ST_RUN)
        else $error("Hold state did not end after clear");

    AST_WARM_REUSE: assert property (seq_warm |=> state_reg == boot_strap_pkg::ST_LOAD && $stable(captured_reg))
        else $error("Warm reset did not reuse captured straps");

    AST_HOLD_SEEN: assert property (seq_release |=> hold_seen_reg == $past(strap_sync_vec.hold))
        else $error("Hold indication does not follow strap");
endmodule
`default_nettype wire

// *** verilog/boot_strap_pkg.sv ***
// Constants and types shared by the boot strap sampler and its helper modules.
// Notes on behaviour
// - Capture the whole strap vector when the fundamental reset pin is released.
// - Outside a fundamental reset sequence the strap pins have no effect.
// - The configuration loader may write any bit of any writable register.
// - Only both common-clock and reset-hold values may be overridden during reset.
// - The status register reports the strap values captured at the last release.
// - Downstream common-clock strap marks downstream ports as sharing the reference clock.
// - Upstream common-clock strap marks the upstream port as sharing the reference clock.
// - Slow-bus strap runs the master bus at 100 kHz, otherwise at 400 kHz.
// - Asserting the fundamental reset pin resets the logic and starts a reset.
// - Each asserted merge strap joins a port pair into one x8 port.
// - Reference-clock strap 0 selects 100 MHz and 1 selects 125 MHz.
// - Reset-hold keeps the device in reset after the sequence, buses stay active.
// - The held state ends only when the agent clears the control hold bit.
// - The captured reset-hold value is overridden by writing the control hold bit.
// - Decode operating mode 0x0, 0x1, 0x8 to 0xB as documented.
// - A warm reset without the pin reuses the previously captured straps.
// - An asserted reset-hold strap sets the hold indication in the status register.
package boot_strap_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BUS_SLOW_HZ = 100_000;
    localparam int unsigned BUS_FAST_HZ = 400_000;
    localparam int unsigned BUS_SLOW_CYC = CLK_HZ / BUS_SLOW_HZ;
    localparam int unsigned BUS_FAST_CYC = CLK_HZ / BUS_FAST_HZ;
    localparam logic [7:0] REF_MHZ_LOW = 8'h64;
    localparam logic [7:0] REF_MHZ_HIGH = 8'h7D;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_EEPROM = 4'h1;
    localparam logic [3:0] MODE_FAIL_P0 = 4'h8;
    localparam logic [3:0] MODE_FAIL_P2 = 4'h9;
    localparam logic [3:0] MODE_EE_FAIL_P0 = 4'hA;
    localparam logic [3:0] MODE_EE_FAIL_P2 = 4'hB;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_WARM_BIT = 1;
    localparam int CTRL_CDOWN_BIT = 2;
    localparam int CTRL_CUP_BIT = 3;
    localparam int STATUS_HOLD_SEEN_BIT = 16;
    localparam int STATUS_RUN_BIT = 17;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    typedef struct packed {
        logic common_down;
        logic common_up;
        logic bus_slow;
        logic [3:0] merge;
        logic ref_rate;
        logic hold;
        logic [3:0] mode;
    } strap_vec_t;
    localparam int STRAP_W = $bits(strap_vec_t);
    localparam strap_vec_t STRAP_RESET = '0;
    typedef struct packed {
        logic normal;
        logic eeprom_init;
        logic failover;
        logic upstream_port2;
        logic reserved;
    } mode_dec_t;
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [31:0] data;
    } reg_write_t;
    typedef enum logic [1:0] {ST_PIN_RESET, ST_LOAD, ST_HOLD, ST_RUN} seq_state_t;
endpackage

// *** verilog/strap_sync.sv ***
// Two-flop synchroniser for a vector of board level inputs.
`timescale 1ns/100ps
`default_nettype none
module strap_sync #(
    parameter int WIDTH = 14
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Asynchronous input and its synchronised copy.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Elaboration refuses a vector with no bits.
    if (WIDTH < 1)
    begin : g_bad_width
        $error("strap_sync needs a width of at least one");
    end

    // The first stage feeds only the second, so metastability settles there.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// *** verilog/mode_decode.sv ***
// Combinational decode of the captured operating mode and port merge straps.
`timescale 1ns/100ps
`default_nettype none
module mode_decode #(
    parameter int PAIRS = 4
) (
    // Captured strap fields.
    input wire logic [3:0] mode,
    input wire logic [PAIRS-1:0] merge,
    // Decoded results.
    output boot_strap_pkg::mode_dec_t dec,
    output logic [PAIRS-1:0] odd_port_enabled
);
    // Elaboration refuses a decoder with no port pairs.
    if (PAIRS < 1)
    begin : g_bad_pairs
        $error("mode_decode needs at least one port pair");
    end

    // Codes 0x8 to 0xB select failover, where bit 1 adds EEPROM load and bit 0 picks port 2; 0x1 loads EEPROM alone.
    // mode code decode
    assign dec.normal = (mode == boot_strap_pkg::MODE_NORMAL);
    assign dec.eeprom_init = (mode == boot_strap_pkg::MODE_EEPROM) ||
        (mode == boot_strap_pkg::MODE_EE_FAIL_P0) || (mode == boot_strap_pkg::MODE_EE_FAIL_P2);
    assign dec.failover = (mode >= boot_strap_pkg::MODE_FAIL_P0) && (mode <= boot_strap_pkg::MODE_EE_FAIL_P2);
    assign dec.upstream_port2 = (mode == boot_strap_pkg::MODE_FAIL_P2) || (mode == boot_strap_pkg::MODE_EE_FAIL_P2);
    assign dec.reserved = !(dec.normal || dec.eeprom_init || dec.failover);

    // A merged pair gives its odd port's lanes to the even port.
    genvar i;
    generate
        for (i = 0; i < PAIRS; i++)
        begin : g_pair
            assign odd_port_enabled[i] = !merge[i];
        end
    endgenerate
endmodule
`default_nettype wire

// *** testbench/board_straps.sv ***
// Board model that drives the boot straps and the fundamental reset pin.
`timescale 1ns/100ps
`default_nettype none
module board_straps (
    // Clock.
    input wire logic ref_clk,
    // Pin and strap levels.
    output logic pin_n,
    output boot_strap_pkg::strap_vec_t straps
);
    // The pin starts asserted with every strap low.
    initial
    begin
        pin_n = 1'b0;
        straps = '0;
    end
    // valid codes only
    // Asserts the pin and sets the straps long before the release edge.
    task automatic drop(input boot_strap_pkg::strap_vec_t v);
        @(posedge ref_clk);
        pin_n <= 1'b0;
        straps <= v;
    endtask
    // Releases the pin; the straps stay as they are.
    task automatic raise();
        @(posedge ref_clk);
        pin_n <= 1'b1;
    endtask
    // mode pins static
    // Moves every strap except the mode field while the core runs.
    task automatic disturb(input boot_strap_pkg::strap_vec_t v);
        @(posedge ref_clk);
        straps <= {v[12:4], straps.mode};
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_boot_strap_sampler.sv ***
// Self-checking testbench for the boot strap sampler.
`timescale 1ns/100ps
`default_nettype none
module tb_boot_strap_sampler;
    logic ref_clk, reset, hsel, hwrite, loader_done, pin_n, hreadyout, hresp, rdy_q;
    logic fund_reset_active, core_hold, bus_enable, cd, cu, bus_slow, bus_tick, ref_125, loader_request;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] merged, odd_en;
    logic [7:0] ref_mhz;
    boot_strap_pkg::reg_write_t loader_write;
    boot_strap_pkg::mode_dec_t mode;
    boot_strap_pkg::strap_vec_t st;
    int n_errors = 0;
    int samples_checked = 0;
    board_straps i_board (.ref_clk(ref_clk), .pin_n(pin_n), .straps(st));
    boot_strap_sampler i_dut (.ref_clk(ref_clk), .reset(reset), .fundamental_reset_n(pin_n),
        .common_clock_down_strap(st.common_down), .common_clock_up_strap(st.common_up),
        .master_bus_slow_strap(st.bus_slow), .merge_ports_0_1_strap(st.merge[0]),
        .merge_ports_2_3_strap(st.merge[1]), .merge_ports_4_5_strap(st.merge[2]),
        .merge_ports_6_7_strap(st.merge[3]), .ref_clock_rate_strap(st.ref_rate),
        .reset_hold_strap(st.hold), .operating_mode_strap(st.mode), .loader_write(loader_write),
        .loader_done(loader_done), .loader_request(loader_request), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fund_reset_active(fund_reset_active),
        .core_hold(core_hold), .bus_enable(bus_enable), .common_clock_down(cd), .common_clock_up(cu),
        .bus_slow(bus_slow), .bus_tick(bus_tick), .port_merged(merged), .odd_port_enabled(odd_en),
        .ref_clock_125(ref_125), .ref_clock_mhz(ref_mhz), .mode(mode));
    // Free-running core clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Captures the bus answer exactly at the edge so reads never race the design.
    always @(posedge ref_clk)
    begin
        rd_q <= hrdata;
        rdy_q <= hreadyout;
    end
    task automatic complete_run();
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Waits for hready under a bound; a hang ends the run.
    task automatic wait_ready();
        int i;
        i = 0;
        do
        begin
            cyc(1);
            i++;
        end
        while (rdy_q !== 1'b1 && i < 20);
        if (rdy_q !== 1'b1)
        begin
            n_errors++;
            complete_run();
        end
    endtask
    // One single word transfer: address phase, then data phase.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        check("hresp", 32'h0, {31'h0, hresp});
        r = rd_q;
    endtask
    task automatic boot(input boot_strap_pkg::strap_vec_t v);
        i_board.drop(v);
        cyc(6);
        check("fund_reset_active", 32'h1, {31'h0, fund_reset_active});
        i_board.raise();
        cyc(12);
    endtask
    // Counts the cycles between two divider ticks.
    task automatic tick_gap(input logic [31:0] exp);
        int n;
        n = 0;
        while (bus_tick !== 1'b1 && n < 600)
        begin
            cyc(1);
            n++;
        end
        if (n >= 600)
        begin
            n_errors++;
            complete_run();
        end
        n = 0;
        do
        begin
            cyc(1);
            n++;
        end
        while (bus_tick !== 1'b1 && n < 600);
        if (n >= 600)
        begin
            n_errors++;
            complete_run();
        end
        check("bus_tick gap", exp, n);
    endtask
    task automatic t_capture();
        logic [31:0] r;
        boot(13'h1560);
        ahb(1'b0, 32'(boot_strap_pkg::STATUS_ADDR), 32'h0, r);
        check("status", 32'h1560, {19'h0, r[12:0]});
        check("merged", 32'h5, {28'h0, merged});
        check("odd_en", 32'hA, {28'h0, odd_en});
        check("ref_mhz", 32'h7D, {24'h0, ref_mhz});
        check("slow ref", 32'h3, {30'h0, bus_slow, ref_125});
        check("common", 32'h2, {30'h0, cd, cu});
        tick_gap(boot_strap_pkg::BUS_SLOW_CYC);
        i_board.disturb(13'h0A90);
        cyc(10);
        ahb(1'b0, 32'(boot_strap_pkg::STATUS_ADDR), 32'h0, r);
        check("status kept", 32'h1560, {19'h0, r[12:0]});
        check("merged kept", 32'h5, {28'h0, merged});
        ahb(1'b1, 32'(boot_strap_pkg::CTRL_ADDR), 32'h2, r);
        cyc(10);
        ahb(1'b0, 32'(boot_strap_pkg::STATUS_ADDR), 32'h0, r);
        check("warm status", 32'h1560, {19'h0, r[12:0]});
        check("warm run", 32'h2, {30'h0, cd, core_hold});
        ahb(1'b0, 32'h8, 32'h0, r);
        check("unmapped", 32'h0, r);
    endtask
    task automatic t_hold();
        logic [31:0] r;
        boot(13'h0A90);
        check("held", 32'h3, {30'h0, core_hold, bus_enable});
        ahb(1'b0, 32'(boot_strap_pkg::STATUS_ADDR), 32'h0, r);
        check("hold seen", 32'h1, {31'h0, r[16]});
        check("ref_mhz", 32'h64, {24'h0, ref_mhz});
        check("fast ref", 32'h0, {30'h0, bus_slow, ref_125});
        tick_gap(boot_strap_pkg::BUS_FAST_CYC);
        ahb(1'b1, 32'(boot_strap_pkg::CTRL_ADDR), 32'h4, r);
        cyc(4);
        check("override", 32'h4, {29'h0, cd, cu, core_hold});
    endtask
    task automatic t_modes();
        // Ends on a mode without loader so the loader scenario starts from a different decode.
        logic [3:0] codes[6] = '{4'hA, 4'hB, 4'h1, 4'h0, 4'h8, 4'h9};
        logic [3:0] e;
        foreach (codes[k])
        begin
            boot({9'h0, codes[k]});
            e = codes[k][3] ? {codes[k][1], 1'b1, codes[k][0], 1'b0} : {codes[k][0], 3'h0};
            check("mode", {27'h0, codes[k] == 4'h0, e}, {27'h0, mode.normal, mode.eeprom_init, mode.failover,
                mode.upstream_port2, mode.reserved});
        end
    endtask
    task automatic t_loader();
        loader_done <= 1'b0;
        boot(13'h0001);
        check("loading", 32'h3, {30'h0, loader_request, core_hold});
        loader_write <= '{1'b1, boot_strap_pkg::CTRL_ADDR, 32'h8};
        cyc(1);
        loader_write <= '0;
        loader_done <= 1'b1;
        cyc(4);
        check("loaded", 32'h2, {30'h0, cu, core_hold});
    endtask
    // Main sequence: reset for four cycles, then every scenario in turn.
    initial
    begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        loader_done = 1'b1;
        loader_write = '0;
        cyc(4);
        reset <= 1'b0;
        cyc(1);
        t_capture();
        t_hold();
        t_modes();
        t_loader();
        complete_run();
    end
endmodule
`default_nettype wire
